/* common/sas_pkg.sv */
package sas_pkg;

    localparam int unsigned CORE_CLK_MHZ   = 200;
    localparam int unsigned CORE_PERIOD_PS = 1000000 / CORE_CLK_MHZ;
    localparam int unsigned FRC_TAD_NS     = 4000;
    localparam int unsigned FRC_TAD_CYC    = (FRC_TAD_NS * 1000) / CORE_PERIOD_PS;
    localparam int unsigned INSTR_CYC      = 4;
    localparam int unsigned RES_W          = 10;
    localparam int unsigned CONV_TADS      = 11;
    localparam int unsigned ABORT_TADS     = 2;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ASEL = 8'h04;
    localparam logic [7:0] OFS_RESH = 8'h08;
    localparam logic [7:0] OFS_RESL = 8'h0c;
    localparam logic [7:0] OFS_FLAG = 8'h10;
    localparam logic [7:0] OFS_IEN  = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;

    localparam int unsigned CTRL_JUST = 7;
    localparam int unsigned CTRL_VREF = 6;
    localparam int unsigned CTRL_CHS  = 2;
    localparam int unsigned CTRL_GO   = 1;
    localparam int unsigned CTRL_EN   = 0;
    localparam int unsigned ASEL_CS   = 4;
    localparam int unsigned ASEL_AN   = 0;
    localparam int unsigned FLAG_DONE = 6;
    localparam int unsigned IEN_DONE  = 6;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] ASEL_RST = 8'h0f;
    localparam logic       FLAG_RST = 1'b0;
    localparam logic       IEN_RST  = 1'b0;

    typedef enum {ST_IDLE, ST_START_DLY, ST_CONV, ST_ABORT_WAIT} sas_state_t;

    function automatic logic sas_is_frc(input logic [2:0] sel);
        return sel[1:0] == 2'b11;
    endfunction : sas_is_frc

    // core clocks per conversion-clock period
    function automatic logic [6:0] sas_div_ratio(input logic [2:0] sel);
        case (sel)
            3'h0:    return 7'h02;
            3'h4:    return 7'h04;
            3'h1:    return 7'h08;
            3'h5:    return 7'h10;
            3'h2:    return 7'h20;
            3'h6:    return 7'h40;
            default: return 7'h00;
        endcase
    endfunction : sas_div_ratio

endpackage : sas_pkg

/* src/sas_tad_div.sv */
`timescale 1ns/1ps
module sas_tad_div
    import sas_pkg::*;
#(
    parameter int unsigned FRC_CYC = FRC_TAD_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       clr,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    // one-cycle conversion-clock enable
    output logic            tick
);
    localparam int CW = ($clog2(FRC_CYC + 1) > 7) ? $clog2(FRC_CYC + 1) : 7;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } sas_div_st_t;

    sas_div_st_t st_r;
    sas_div_st_t st_nxt;
    logic [CW-1:0] period;

    always_comb begin
        st_nxt = st_r;
        // oscillator modelled as a fixed core-clock divide
        period = sas_is_frc(sel) ? CW'(FRC_CYC) : CW'(sas_div_ratio(sel)); // RL3
        st_nxt.tick = 1'b0;
        if (!run || clr) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == period - CW'(1)) begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

endmodule : sas_tad_div

/* src/sas_sar_core.sv */
`timescale 1ns/1ps
module sas_sar_core
    import sas_pkg::*;
#(
    parameter int unsigned W = RES_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // sequencing
    input  wire logic         tick,
    input  wire logic         start,
    input  wire logic         abort,
    input  wire logic         cmp_hi,
    // results
    output logic [W-1:0]      trial,
    output logic              busy,
    output logic              done,
    output logic [W-1:0]      result
);
    typedef struct packed {
        logic [3:0]   cnt;
        logic [W-1:0] code;
        logic [W-1:0] res;
        logic         busy;
        logic         done;
    } sas_sar_st_t;

    sas_sar_st_t st_r;
    sas_sar_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (abort) begin
            // result kept: no partial update
            st_nxt.busy = 1'b0; // RL11
            st_nxt.code = '0;
        end else if (start) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt  = '0;
            st_nxt.code = '0;
        end else if (st_r.busy && tick) begin
            // period 0 samples, periods 1..W resolve a bit each
            for (int i = 0; i < W; i++) begin
                if (st_r.cnt != 4'h0 && i == W - int'(st_r.cnt) && !cmp_hi) begin
                    st_nxt.code[i] = 1'b0; // RL1
                end
                if (i == W - 1 - int'(st_r.cnt)) begin
                    st_nxt.code[i] = 1'b1;
                end
            end
            st_nxt.cnt = st_r.cnt + 4'h1;
            if (st_r.cnt == 4'(CONV_TADS - 1)) begin
                st_nxt.busy = 1'b0; // RL4
                st_nxt.done = 1'b1;
                st_nxt.res  = st_nxt.code;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign trial  = st_r.code;
    assign busy   = st_r.busy;
    assign done   = st_r.done;
    assign result = st_r.res;

endmodule : sas_sar_core

/* src/sas_adc_seq.sv */
// What this block does
// RL1 - ten-bit result by successive approximation, stored in result pair
// RL2 - control bit picks supply or external pin as positive reference; negative is ground
// RL3 - clock select picks system clock /2 to /64, or oscillator
// RL4 - one full conversion lasts exactly eleven conversion-clock periods
// RL5 - done flag sets at every completion regardless of interrupt enable
// RL6 - software clears the done flag; hardware never clears it
// RL7 - completion with interrupt enabled wakes a sleeping device
// RL8 - enable bit powers converter; writing one to go starts conversion
// RL9 - software enables converter first, sets go in a later write
// RL10 - completion clears go, sets done flag, loads both result registers
// RL11 - clearing go early aborts; result registers keep previous value untouched
// RL12 - after abort wait two conversion periods, then acquire
// RL13 - reset returns all control state to defaults, ending any conversion
// RL14 - with oscillator clock, start is delayed one extra instruction cycle
// RL15 - sleep, oscillator, irq off: powers down after completing
// RL16 - sleep on divided clock aborts and powers down, enable stays
// RL17 - capture/compare trigger sets go and clears the timer
// RL18 - format bit selects left or right justification of result
// RL19 - channel field picks which input feeds the sample-and-hold
// RL20 - software waits acquisition time after a channel change
// RL21 - left: high holds bits 9-2; right: high holds 9-8; unused read zero
// RL22 - channel codes 0-3 pins, 4 comparator ref, 5 0.6 V, 6 1.2 V, 7 reserved
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module sas_adc_seq
    import sas_pkg::*;
#(
    parameter int unsigned FRC_CYC = FRC_TAD_CYC
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // core power state
    input  wire logic        sleep_in,
    output logic             wake_req,
    output logic             done_irq,
    // special event trigger
    input  wire logic        special_event_trig,
    output logic             timer1_clear,
    // analog front end
    input  wire logic        cmp_in,
    output logic [9:0]       dac_code,
    output logic             sample_close,
    output logic [6:0]       chan_onehot,
    output logic             pos_ref_ext,
    output logic             conv_active,
    output logic             analog_power,
    output logic [3:0]       analog_pins
);

    typedef struct packed {
        logic             justify;
        logic             vref;
        logic [2:0]       channel_select;
        logic             go;
        logic             en;
        logic [2:0]       csel;
        logic [3:0]       analog_select_reg;
        logic             flag;
        logic             ien;
        logic [RES_W-1:0] res;
        logic [1:0]       st;
        logic [1:0]       dly;
        logic [1:0]       tads;
        logic             off;
        logic             ack;
        logic [31:0]      rdata;
        logic             tmr_clr;
        logic             wake;
    } sas_seq_st_t;

    sas_seq_st_t st_r;
    sas_seq_st_t st_nxt;

    logic [1:0]       rst_sync_r;
    logic             rst_q_n;
    logic [1:0]       cmp_sync_r;
    logic             tick;
    logic             div_run;
    logic             div_clr;
    logic             sar_start;
    logic             sar_abort;
    logic             sar_busy;
    logic             sar_done;
    logic [RES_W-1:0] sar_trial;
    logic [RES_W-1:0] sar_result;
    logic             req;
    logic             wr_fire;
    logic             frc;
    logic             sleep_abort;
    logic [7:0]       ctrl_rd;
    logic [15:0]      res_rd;
    sas_state_t       cur;

    // retimed release so all flops leave reset together
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_q_n = rst_sync_r[1];

    // comparator is asynchronous: two flops first
    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            cmp_sync_r <= 2'b00;
        end else begin
            cmp_sync_r <= {cmp_sync_r[0], cmp_in};
        end
    end

    // result pair as seen by software
    function automatic logic [15:0] sas_fmt_res(input logic just, input logic [RES_W-1:0] r);
        if (just) begin
            return {6'h00, r[9:8], r[7:0]};
        end
        return {r[9:2], r[1:0], 6'h00};
    endfunction : sas_fmt_res

    function automatic logic [6:0] sas_chan_dec(input logic [2:0] c);
        if (c == 3'h7) begin
            return 7'h00;
        end
        return 7'(8'h01 << c);
    endfunction : sas_chan_dec

    assign cur         = sas_state_t'(st_r.st);
    assign frc         = sas_is_frc(st_r.csel);
    assign req         = avs_read | avs_write;
    assign wr_fire     = avs_write & st_r.ack;
    assign sleep_abort = sleep_in & ~frc & (cur != ST_IDLE); // RL16
    assign ctrl_rd     = {st_r.justify, st_r.vref, 1'b0, st_r.channel_select, st_r.go, st_r.en};
    assign res_rd      = sas_fmt_res(st_r.justify, st_r.res); // RL21 RL18

    // one wait state keeps read data from a flop
    assign avs_waitrequest = req & ~st_r.ack;

    always_comb begin
        st_nxt    = st_r;
        sar_start = 1'b0;
        sar_abort = 1'b0;
        div_clr   = 1'b0;
        st_nxt.tmr_clr = 1'b0;
        st_nxt.wake    = 1'b0;

        // bus slave
        st_nxt.ack = req & ~st_r.ack;
        if (req && !st_r.ack) begin
            case (avs_address)
                OFS_CTRL: st_nxt.rdata = {24'h0, ctrl_rd};
                OFS_ASEL: st_nxt.rdata = {25'h0, st_r.csel, st_r.analog_select_reg};
                OFS_RESH: st_nxt.rdata = {24'h0, res_rd[15:8]};
                OFS_RESL: st_nxt.rdata = {24'h0, res_rd[7:0]};
                OFS_FLAG: st_nxt.rdata = 32'(st_r.flag) << FLAG_DONE;
                OFS_IEN:  st_nxt.rdata = 32'(st_r.ien) << IEN_DONE;
                OFS_STAT: st_nxt.rdata = {28'h0, st_r.off, sar_busy, st_r.st};
                default:  st_nxt.rdata = 32'h0;
            endcase
        end

        if (wr_fire) begin
            case (avs_address)
                OFS_CTRL: begin
                    st_nxt.justify = avs_writedata[CTRL_JUST]; // RL18
                    st_nxt.vref    = avs_writedata[CTRL_VREF]; // RL2
                    st_nxt.channel_select     = avs_writedata[CTRL_CHS +: 3]; // RL19
                    st_nxt.go      = avs_writedata[CTRL_GO]; // RL8
                    st_nxt.en      = avs_writedata[CTRL_EN]; // RL8
                end
                OFS_ASEL: begin
                    st_nxt.csel  = avs_writedata[ASEL_CS +: 3]; // RL3
                    st_nxt.analog_select_reg = avs_writedata[ASEL_AN +: 4];
                end
                OFS_FLAG: st_nxt.flag = avs_writedata[FLAG_DONE]; // RL6
                OFS_IEN:  st_nxt.ien  = avs_writedata[IEN_DONE];
                default: ;
            endcase
        end

        // trigger wins over a same-cycle software go clear
        if (special_event_trig) begin
            st_nxt.tmr_clr = 1'b1; // RL17
            if (st_nxt.en) begin
                st_nxt.go = 1'b1; // RL17
            end
        end

        if (!sleep_in) begin
            st_nxt.off = 1'b0;
        end

        case (cur)
            ST_IDLE: begin
                // go with enable in one write still starts
                if (st_r.go && st_r.en && !st_r.off && !(sleep_in && !frc)) begin // RL9
                    if (frc) begin
                        st_nxt.st  = 2'(ST_START_DLY); // RL14
                        st_nxt.dly = '0;
                    end else begin
                        sar_start = 1'b1; // RL8
                        div_clr   = 1'b1;
                        st_nxt.st = 2'(ST_CONV);
                    end
                end
            end
            ST_START_DLY: begin
                // lets the core enter sleep before conversion noise
                st_nxt.dly = st_r.dly + 2'h1;
                if (st_r.dly == 2'(INSTR_CYC - 1)) begin
                    sar_start = 1'b1; // RL14
                    div_clr   = 1'b1;
                    st_nxt.st = 2'(ST_CONV);
                end
            end
            ST_CONV: begin
                if (sar_done) begin
                    st_nxt.st = 2'(ST_IDLE);
                end
            end
            ST_ABORT_WAIT: begin
                if (tick) begin
                    st_nxt.tads = st_r.tads + 2'h1;
                    if (st_r.tads == 2'(ABORT_TADS - 1)) begin
                        st_nxt.st = 2'(ST_IDLE); // RL12
                    end
                end
            end
            default: st_nxt.st = 2'(ST_IDLE);
        endcase

        // software abort: go cleared while pending or running
        if ((cur == ST_CONV || cur == ST_START_DLY) && !st_nxt.go && !sar_done) begin
            sar_abort   = 1'b1; // RL11
            div_clr     = 1'b1;
            st_nxt.tads = '0;
            st_nxt.st   = 2'(ST_ABORT_WAIT); // RL12
        end

        // disable or divided-clock sleep ends all at once
        if (!st_r.en || sleep_abort) begin
            if (cur != ST_IDLE) begin
                sar_abort = 1'b1; // RL16
            end
            st_nxt.st = 2'(ST_IDLE);
            if (sleep_abort) begin
                st_nxt.go  = 1'b0; // RL16
                st_nxt.off = 1'b1; // RL16
            end
        end

        if (sar_done && st_r.en) begin
            st_nxt.res  = sar_result; // RL10
            st_nxt.go   = 1'b0; // RL10
            st_nxt.flag = 1'b1; // RL5
            if (sleep_in && st_r.ien) begin
                st_nxt.wake = 1'b1; // RL7
            end
            if (sleep_in && frc && !st_r.ien) begin
                st_nxt.off = 1'b1; // RL15
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            st_r         <= '0; // RL13
            st_r.justify <= CTRL_RST[CTRL_JUST];
            st_r.vref    <= CTRL_RST[CTRL_VREF];
            st_r.channel_select     <= CTRL_RST[CTRL_CHS +: 3];
            st_r.go      <= CTRL_RST[CTRL_GO];
            st_r.en      <= CTRL_RST[CTRL_EN];
            st_r.csel    <= ASEL_RST[ASEL_CS +: 3];
            st_r.analog_select_reg   <= ASEL_RST[ASEL_AN +: 4];
            st_r.flag    <= FLAG_RST;
            st_r.ien     <= IEN_RST;
            st_r.st      <= 2'(ST_IDLE);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign div_run = (cur == ST_CONV) || (cur == ST_ABORT_WAIT);

    sas_tad_div #(
        .FRC_CYC (FRC_CYC)
    ) u_div (
        .clk   (core_clk),
        .rst_n (rst_q_n),
        .clr   (div_clr),
        .run   (div_run),
        .sel   (st_r.csel),
        .tick  (tick)
    );

    sas_sar_core #(
        .W (RES_W)
    ) u_sar (
        .clk    (core_clk),
        .rst_n  (rst_q_n),
        .tick   (tick),
        .start  (sar_start),
        .abort  (sar_abort),
        .cmp_hi (cmp_sync_r[1]),
        .trial  (sar_trial),
        .busy   (sar_busy),
        .done   (sar_done),
        .result (sar_result)
    );

    assign avs_readdata = st_r.rdata;
    assign done_irq     = st_r.flag & st_r.ien;
    assign wake_req     = st_r.wake;
    assign timer1_clear = st_r.tmr_clr;
    assign dac_code     = sar_trial;
    assign conv_active  = sar_busy;
    assign analog_power = st_r.en & ~st_r.off;
    // hold opens for conversion and the post-abort wait
    assign sample_close = analog_power & (cur == ST_IDLE || cur == ST_START_DLY); // RL12
    assign chan_onehot  = analog_power ? sas_chan_dec(st_r.channel_select) : 7'h00; // RL22 RL19
    assign pos_ref_ext  = st_r.vref; // RL2
    assign analog_pins  = st_r.analog_select_reg;

endmodule : sas_adc_seq

/* dv/sas_afe_model.sv */
`timescale 1ns/1ps
module sas_afe_model (
    // trial code and input level
    input  wire logic [9:0] dac_code,
    input  wire logic [9:0] lvl,
    input  wire logic       analog_power,
    // comparator decision
    output logic            cmp_in
);
    // level sits half a step above its code
    assign cmp_in = analog_power && ({lvl, 1'b1} > {dac_code, 1'b0});
endmodule : sas_afe_model

/* dv/sas_adc_seq_asserts.sv */
`timescale 1ns/1ps
module sas_adc_seq_chk
    import sas_pkg::*;
#(
    parameter int unsigned FRC_CYC = FRC_TAD_CYC
) (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // bus
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    // events
    input wire logic       wake_req,
    input wire logic       done_irq,
    input wire logic       special_event_trig,
    input wire logic       timer1_clear,
    // analog side
    input wire logic       conv_active,
    input wire logic       sample_close,
    input wire logic       analog_power,
    input wire logic [6:0] chan_onehot
);
    // longest conversion plus slack
    localparam int CONV_MAX = 11 * ((FRC_CYC > 64) ? FRC_CYC : 64) + 2;
    int run_len;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) run_len <= 0;
        else run_len <= conv_active ? run_len + 1 : 0;
    end

    wait_state_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("second wait state");
    conv_power_a: assert property ($rose(conv_active) |-> analog_power)
        else $error("start unpowered");
    conv_len_a: assert property (conv_active |-> run_len < CONV_MAX)
        else $error("conversion too long");
    trig_clear_a: assert property (special_event_trig && analog_power |=> timer1_clear)
        else $error("no timer clear");
    clear_cause_a: assert property (timer1_clear |-> $past(special_event_trig))
        else $error("stray timer clear");
    wake_pulse_a: assert property (wake_req |=> !wake_req)
        else $error("long wake pulse");
    wake_irq_a: assert property (wake_req |-> done_irq)
        else $error("wake without irq");
    hold_open_a: assert property (conv_active |-> !sample_close)
        else $error("hold closed in conversion");
    chan_off_a: assert property (!analog_power |-> chan_onehot == 7'h00)
        else $error("channel while unpowered");
    chan_one_a: assert property ($onehot0(chan_onehot))
        else $error("several channels");

    conv_run_c: cover property ($fell(conv_active));
    wake_c:     cover property (wake_req);
    trig_c:     cover property (special_event_trig ##1 timer1_clear);
endmodule : sas_adc_seq_chk

bind sas_adc_seq sas_adc_seq_chk #(.FRC_CYC(FRC_CYC)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .wake_req(wake_req), .done_irq(done_irq),
    .special_event_trig(special_event_trig), .timer1_clear(timer1_clear),
    .conv_active(conv_active), .sample_close(sample_close), .analog_power(analog_power),
    .chan_onehot(chan_onehot)
);

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import sas_pkg::*;
    localparam int unsigned FRC = 4;
    logic        core_clk, rst_n, avs_read, avs_write, sleep_in, special_event_trig, cmp_in;
    logic        avs_waitrequest, wake_req, done_irq, timer1_clear, sample_close;
    logic        pos_ref_ext, conv_active, analog_power, act_q;
    logic [7:0]  avs_address, rv;
    logic [31:0] avs_writedata, avs_readdata;
    logic [9:0]  dac_code, lvl, last_v;
    logic [6:0]  chan_onehot;
    logic [3:0]  analog_pins;
    int          cyc, act_len, t1c, wk, taken_at, rise_at, n_fail, samples_checked;

    sas_adc_seq #(.FRC_CYC(FRC)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sleep_in(sleep_in), .wake_req(wake_req),
        .done_irq(done_irq), .special_event_trig(special_event_trig), .timer1_clear(timer1_clear),
        .cmp_in(cmp_in), .dac_code(dac_code), .sample_close(sample_close), .chan_onehot(chan_onehot),
        .pos_ref_ext(pos_ref_ext), .conv_active(conv_active), .analog_power(analog_power),
        .analog_pins(analog_pins)
    );
    sas_afe_model afe (.dac_code(dac_code), .lvl(lvl), .analog_power(analog_power), .cmp_in(cmp_in));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc   <= cyc + 1;
        act_q <= conv_active;
        if (conv_active === 1'b1) act_len <= act_len + 1;
        if (conv_active === 1'b1 && act_q !== 1'b1) rise_at <= cyc;
        if (timer1_clear === 1'b1) t1c <= t1c + 1;
        if (wake_req === 1'b1) wk <= wk + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_read      <= !w;
        avs_write     <= w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rv       = avs_readdata[7:0];
        taken_at = cyc;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask : rd

    task automatic wait_idle;
        do rd(OFS_CTRL); while (rv[CTRL_GO] === 1'b1);
    endtask : wait_idle

    task automatic t_regs;
        wr(8'h1c, 8'hff);
        rd(8'h1c);
        chk("unmapped", 8'h00, rv);
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CTRL, {1'b0, c[0], 1'b0, c[2:0], 2'b01});
            @(negedge core_clk);
            chk("channel", c == 7 ? 7'h00 : 7'(1 << c), chan_onehot);
            chk("reference", c[0], pos_ref_ext);
        end
    endtask : t_regs

    task automatic t_convs;
        logic [2:0] sels [7] = '{3'h3, 3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
        int ns [7] = '{FRC, 2, 4, 8, 16, 32, 64};
        int dly [7];
        int a0;
        for (int i = 0; i < 7; i++) begin
            last_v = 10'h2c5 ^ 10'(i * 73);
            lvl <= last_v;
            wr(OFS_ASEL, {1'b0, sels[i], 4'hf});
            wr(OFS_FLAG, 8'h00);
            wr(OFS_CTRL, {i[0], 7'h01});
            a0 = act_len;
            wr(OFS_CTRL, {i[0], 7'h03});
            dly[i] = taken_at;
            wait_idle();
            dly[i] = rise_at - dly[i];
            chk("length", 1, (act_len - a0) inside {[11 * ns[i] - 1:11 * ns[i] + 1]});
            rd(OFS_CTRL);
            chk("control at end", {i[0], 7'h01}, rv);
            rd(OFS_FLAG);
            chk("done flag", 8'h40, rv);
            if (ns[i] >= 8) begin
                rd(OFS_RESH);
                chk("result high", i[0] ? {6'h0, last_v[9:8]} : last_v[9:2], rv);
                rd(OFS_RESL);
                chk("result low", i[0] ? last_v[7:0] : {last_v[1:0], 6'h0}, rv);
            end
        end
        chk("start delay", 4, dly[0] - dly[3]);
    endtask : t_convs

    task automatic t_abort;
        int t0;
        lvl <= ~last_v;
        wr(OFS_ASEL, 8'h6f);
        wr(OFS_CTRL, 8'h03);
        repeat (200) @(posedge core_clk);
        wr(OFS_CTRL, 8'h01);
        t0 = taken_at;
        do @(negedge core_clk); while (sample_close !== 1'b1);
        chk("acquire after abort", 1, (cyc - t0) inside {[128:134]});
        rd(OFS_CTRL);
        chk("ctrl abort", 8'h01, rv);
        rd(OFS_RESH);
        chk("result kept", last_v[9:2], rv);
    endtask : t_abort

    task automatic t_trig;
        int t1;
        wr(OFS_ASEL, 8'h1f);
        wr(OFS_FLAG, 8'h00);
        t1 = t1c;
        special_event_trig <= 1'b1;
        @(posedge core_clk);
        special_event_trig <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("timer clears", t1 + 1, t1c);
        wait_idle();
        rd(OFS_FLAG);
        chk("trigger flag", 8'h40, rv);
    endtask : t_trig

    task automatic t_sleep;
        int w0;
        wr(OFS_IEN, 8'h40);
        wr(OFS_CTRL, 8'h03);
        repeat (20) @(posedge core_clk);
        sleep_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("power in sleep", 0, analog_power);
        rd(OFS_CTRL);
        chk("ctrl sleep abort", 8'h01, rv);
        sleep_in <= 1'b0;
        wr(OFS_ASEL, 8'h3f);
        for (int k = 0; k < 2; k++) begin
            w0 = wk;
            wr(OFS_IEN, k ? 8'h00 : 8'h40);
            wr(OFS_CTRL, 8'h03);
            sleep_in <= 1'b1;
            repeat (100) @(posedge core_clk);
            chk("wake pulses", w0 + 1 - k, wk);
            chk("power after sleep run", 1 - k, analog_power);
            chk("irq", 1 - k, done_irq);
            rd(OFS_CTRL);
            chk("ctrl sleep run", 8'h01, rv);
            sleep_in <= 1'b0;
            wr(OFS_FLAG, 8'h00);
        end
    endtask : t_sleep

    task automatic t_rst;
        wr(OFS_ASEL, 8'h6f);
        wr(OFS_CTRL, 8'hc3);
        repeat (50) @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("busy in reset", 0, conv_active);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("pins after reset", 4'hf, analog_pins);
        rd(OFS_CTRL);
        chk("ctrl reset", 8'h00, rv);
        rd(OFS_ASEL);
        chk("select reset", 8'h0f, rv);
    endtask : t_rst

    task automatic results;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        sleep_in = 1'b0;
        special_event_trig = 1'b0;
        lvl = 10'h000;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_convs();
        t_abort();
        t_trig();
        t_sleep();
        t_rst();
        results();
    end
endmodule : testbench
